// [hdl/pnpee_ctrl.sv]
// Serial EEPROM access: power-up defaults, host reads and writes, pin sharing.
// Assumes an Avalon-MM master on clk and a three-wire serial EEPROM on the pins.
// Notes on behaviour
// [R1] Low four bits of each interrupt byte pick the ISA level; 0 is none, 3,4,5,7,10,11,12,15 map.
// [R2] Bits 5:4 give the output type: low edge, low level, high edge, high level.
// [R3] Bit 6 set means the card input is active low, clear means active high.
// [R4] The driven level follows input and polarity; bit 4 has no internal effect.
// [R5] Each used interrupt entry must be stored with its own distinct level.
// [R6] Activation low bits enable logical devices 3..0, only when the enable pin allows.
// [R7] EEPROM reads are served only in the configuration state.
// [R8] Bytes come one per data read from address 0, the read pointer stepping each byte.
// [R9] The host polls status for ready data before each data read.
// [R10] Writing 0x03 to config register 0x26 clears the read pointer; reset the part afterwards.
// [R11] EEPROM writes act only in the configuration state.
// [R12] A separate write pointer, zero at reset, is never touched by reads.
// [R13] Writes go enable, then words from address 0 upward, then disable.
// [R14] After each word write the host waits the EEPROM write cycle, about 10 ms.
// [R15] EEPROM pins float in wait-for-key, except while loading defaults after reset.
// [R16] An invalid level code drives no ISA interrupt line.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pnpee_regs.svh"
module pnpee_ctrl #(
    parameter int AW = 6,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic ee_cs,
    output logic ee_cs_oe,
    output logic ee_sk,
    output logic ee_sk_oe,
    output logic ee_di,
    output logic ee_di_oe,
    input wire logic ee_do,
    input wire logic activation_enable_pin,
    input wire logic [3:0] card_irq,
    output logic [15:0] isa_irq,
    output logic [15:0] isa_irq_oe,
    output logic [3:0] ld_activate
);
    import pnpee_pkg::*;
    localparam int FL = 3 + AW + 16;
    localparam int SKH = `PNPEE_SK_HALF_CYC;
    localparam int IRQ0 = `PNPEE_EE_IRQA - `PNPEE_EE_BASE;

    if (AW < 4 || AW > 10 || SKH < 1 || SKH > 255 || FIFO_DEPTH < 2) begin : g_bad_param
        $error("pnpee_ctrl: AW must be 4..10 and FIFO_DEPTH at least 2");
    end

    pnpee_hstate_t hstate_ff, nxt_hstate;
    pnpee_eng_t eng_ff, nxt_eng;
    logic [31:0] rdata_ff, nxt_rdata;
    logic rd_pend_ff, nxt_rd_pend;
    logic [AW:0] rptr_ff, nxt_rptr;
    logic [AW-1:0] wptr_ff, nxt_wptr;
    logic wen_ff, nxt_wen;
    logic init_ff, nxt_init;
    logic [1:0] cnt_ff, nxt_cnt;
    logic [3:0] act_ff, nxt_act;
    logic [FL-1:0] tx_ff, nxt_tx;
    logic [15:0] rx_ff, nxt_rx;
    logic [4:0] bit_ff, nxt_bit;
    logic [4:0] nbits_ff, nxt_nbits;
    logic [7:0] div_ff, nxt_div;
    logic cs_ff, nxt_cs;
    logic sk_ff, nxt_sk;
    logic op_rd_ff, nxt_op_rd;
    logic [7:0] shad_ff [6];
    logic [7:0] nxt_shad [6];
    logic [15:0] irq_ff, nxt_irq, irq_oe_ff, nxt_irq_oe;
    logic do_s1_ff, do_s2_ff, aen_s1_ff, aen_s2_ff;
    logic [3:0] cirq_s1_ff, cirq_s2_ff;
    logic eng_hit, acc_wr, in_cfg, ee_oe, rst_cmd;
    logic go, go_rd;
    logic [FL-1:0] go_tx;
    logic [4:0] go_len;
    logic [7:0] wd;
    logic [7:0] rx_hi;

    pnpee_fifo_if #(.W(8)) f ();

    pnpee_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .f(f.fifo)
    );

    // Bus handshake: reads wait one cycle, engine writes wait for the engine
    assign wd = avs_writedata[7:0];
    assign rx_hi = rx_ff[15:8];
    assign eng_hit = (avs_address == `PNPEE_REG_WDATA) || (avs_address == `PNPEE_REG_WCMD)
                     || (avs_address == `PNPEE_REG_CFG);
    assign avs_waitrequest = (avs_read && !rd_pend_ff)
                             || (avs_write && eng_hit && eng_ff != st_idle
                                 && !(avs_address == `PNPEE_REG_CFG
                                      && (eng_ff == st_push_lo || eng_ff == st_push_hi)));
    assign acc_wr = avs_write && !avs_waitrequest;
    assign in_cfg = hstate_ff == hs_config;
    assign rst_cmd = acc_wr && avs_address == `PNPEE_REG_CFG && in_cfg
                     && wd == `PNPEE_CFG_RPTR_RST; // R10
    // Pins float in wait-for-key unless defaults are loading
    assign ee_oe = init_ff || (hstate_ff != hs_wfk); // R15
    assign ee_cs_oe = ee_oe;
    assign ee_sk_oe = ee_oe;
    assign ee_di_oe = ee_oe;
    assign ee_cs = cs_ff;
    assign ee_sk = sk_ff;
    assign ee_di = tx_ff[FL-1];
    assign avs_readdata = rdata_ff;
    assign isa_irq = irq_ff;
    assign isa_irq_oe = irq_oe_ff;
    assign ld_activate = act_ff;

    // Register access and serial engine, next values
    always_comb begin
        nxt_hstate = hstate_ff;
        nxt_eng = eng_ff;
        nxt_rdata = rdata_ff;
        nxt_rd_pend = rd_pend_ff;
        nxt_rptr = rptr_ff;
        nxt_wptr = wptr_ff;
        nxt_wen = wen_ff;
        nxt_init = init_ff;
        nxt_cnt = cnt_ff;
        nxt_act = act_ff;
        nxt_tx = tx_ff;
        nxt_rx = rx_ff;
        nxt_bit = bit_ff;
        nxt_nbits = nbits_ff;
        nxt_div = div_ff;
        nxt_cs = cs_ff;
        nxt_sk = sk_ff;
        nxt_op_rd = op_rd_ff;
        for (int k = 0; k < 6; k++) nxt_shad[k] = shad_ff[k];
        go = 1'b0;
        go_rd = 1'b0;
        go_tx = '0;
        go_len = 5'(FL);
        f.in_valid = 1'b0;
        f.in_data = rx_ff[7:0];
        f.out_ready = 1'b0;
        f.flush = 1'b0;
        // Register reads, answered one cycle later
        if (avs_read && !rd_pend_ff) begin
            nxt_rd_pend = 1'b1;
            case (avs_address)
                `PNPEE_REG_STATE: nxt_rdata = {30'h0, hstate_ff};
                `PNPEE_REG_STATUS: nxt_rdata = {27'h0, !f.in_ready, init_ff, wen_ff,
                                                eng_ff != st_idle, f.out_valid};
                `PNPEE_REG_RDATA: begin
                    // Empty or outside config reads as zero and pops nothing
                    if (in_cfg && f.out_valid) begin // R7 R9
                        nxt_rdata = {24'h0, f.out_data};
                        f.out_ready = 1'b1; // R8
                    end else begin
                        nxt_rdata = 32'h0;
                    end
                end
                `PNPEE_REG_IRQCFG: nxt_rdata = {shad_ff[IRQ0+3], shad_ff[IRQ0+2],
                                                shad_ff[IRQ0+1], shad_ff[IRQ0]};
                `PNPEE_REG_ACT: nxt_rdata = {28'h0, act_ff};
                default: nxt_rdata = 32'h0;
            endcase
        end else if (rd_pend_ff) begin
            nxt_rd_pend = 1'b0;
        end
        // Host state write; the unused code is ignored
        if (acc_wr && avs_address == `PNPEE_REG_STATE && avs_writedata[1:0] != 2'h3) begin
            nxt_hstate = pnpee_hstate_t'(avs_writedata[1:0]);
        end
        unique case (eng_ff)
            st_idle: begin
                if (acc_wr && eng_hit) begin
                    if (avs_address == `PNPEE_REG_WCMD && in_cfg) begin // R11
                        if (wd == `PNPEE_WCMD_EWEN) begin // R13
                            go = 1'b1;
                            nxt_wen = 1'b1;
                            go_tx = {`PNPEE_OP_MISC, `PNPEE_OPX_EWEN, {(AW-2){1'b0}}, 16'h0};
                        end else if (wd == `PNPEE_WCMD_EWDS) begin // R13
                            go = 1'b1;
                            nxt_wen = 1'b0;
                            go_tx = {`PNPEE_OP_MISC, `PNPEE_OPX_EWDS, {(AW-2){1'b0}}, 16'h0};
                        end
                        go_len = 5'(3 + AW);
                    end else if (avs_address == `PNPEE_REG_WDATA && in_cfg && wen_ff) begin
                        // Word write at the write pointer, which then steps
                        go = 1'b1; // R11 R13
                        go_tx = {`PNPEE_OP_WRITE, wptr_ff, avs_writedata[15:0]};
                        nxt_wptr = wptr_ff + 1'b1; // R12
                    end
                end else if (init_ff) begin
                    // Power-up fetch of the stored default words
                    go = 1'b1;
                    go_rd = 1'b1;
                    go_tx = {`PNPEE_OP_READ, AW'(`PNPEE_EE_BASE >> 1) + AW'(cnt_ff), 16'h0};
                end else if (in_cfg && !rst_cmd) begin
                    // Prefetch at the read pointer into the FIFO
                    go = 1'b1; // R7
                    go_rd = 1'b1;
                    go_tx = {`PNPEE_OP_READ, rptr_ff[AW:1], 16'h0}; // R8
                end
            end
            st_shift: begin
                if (div_ff == 8'(SKH - 1)) begin
                    nxt_div = 8'h0;
                    if (!sk_ff) begin
                        nxt_sk = 1'b1;
                        nxt_rx = {rx_ff[14:0], do_s2_ff};
                    end else begin
                        nxt_sk = 1'b0;
                        nxt_tx = tx_ff << 1;
                        nxt_bit = bit_ff + 5'h1;
                        if (bit_ff == nbits_ff - 5'h1) begin
                            nxt_eng = st_gap;
                            nxt_cs = 1'b0;
                        end
                    end
                end else begin
                    nxt_div = div_ff + 8'h1;
                end
            end
            st_gap: begin
                if (div_ff == 8'(SKH - 1)) begin
                    nxt_div = 8'h0;
                    nxt_eng = st_idle;
                    if (op_rd_ff && init_ff) begin
                        for (int k = 0; k < 6; k++) begin
                            if (k == 2 * int'(cnt_ff)) nxt_shad[k] = rx_ff[7:0];
                            if (k == 2 * int'(cnt_ff) + 1) nxt_shad[k] = rx_hi;
                        end
                        nxt_cnt = cnt_ff + 2'h1;
                        if (cnt_ff == `PNPEE_INIT_WORDS - 2'h1) begin
                            nxt_init = 1'b0;
                            // Power-up activation only if the pin allows it
                            nxt_act = aen_s2_ff ? rx_hi[`PNPEE_ACT_BITS] : 4'h0; // R6
                        end
                    end else if (op_rd_ff) begin
                        nxt_eng = st_push_lo;
                    end
                end else begin
                    nxt_div = div_ff + 8'h1;
                end
            end
            st_push_lo: begin
                f.in_valid = 1'b1;
                if (f.in_ready) begin
                    nxt_rptr = rptr_ff + 1'b1; // R8
                    nxt_eng = st_push_hi;
                end
            end
            st_push_hi: begin
                f.in_valid = 1'b1;
                f.in_data = rx_hi;
                if (f.in_ready) begin
                    nxt_rptr = rptr_ff + 1'b1; // R8
                    nxt_eng = st_idle;
                end
            end
        endcase
        // Frame start common to all commands
        if (go) begin
            nxt_eng = st_shift;
            nxt_tx = go_tx;
            nxt_nbits = go_len;
            nxt_op_rd = go_rd;
            nxt_bit = 5'h0;
            nxt_div = 8'h0;
            nxt_sk = 1'b0;
            nxt_cs = 1'b1;
        end
        // Read pointer reset drops buffered and pending bytes
        if (rst_cmd) begin
            nxt_rptr = `PNPEE_PTR_RST; // R10
            f.flush = 1'b1;
            nxt_eng = st_idle;
        end
    end

    // Interrupt steering; distinct stored levels keep lines free of contention
    always_comb begin
        nxt_irq = 16'h0;
        nxt_irq_oe = 16'h0;
        for (int i = 0; i < 4; i++) begin
            // Invalid codes route nowhere; type bit 4 is unused here
            if (!init_ff && pnpee_lvl_ok(shad_ff[IRQ0+i][`PNPEE_IRQ_LVL])) begin // R1 R16 R5 R4
                nxt_irq_oe[shad_ff[IRQ0+i][`PNPEE_IRQ_LVL]] = 1'b1;
                nxt_irq[shad_ff[IRQ0+i][`PNPEE_IRQ_LVL]] = cirq_s2_ff[i]
                    ^ shad_ff[IRQ0+i][`PNPEE_IRQ_POL] // R3
                    ^ !shad_ff[IRQ0+i][`PNPEE_IRQ_TYPE_HI]; // R2
            end
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (reset) begin
            hstate_ff <= hs_wfk;
            eng_ff <= st_idle;
            rdata_ff <= 32'h0;
            rd_pend_ff <= 1'b0;
            rptr_ff <= `PNPEE_PTR_RST;
            wptr_ff <= `PNPEE_PTR_RST; // R12
            wen_ff <= `PNPEE_WEN_RST;
            init_ff <= 1'b1;
            cnt_ff <= 2'h0;
            act_ff <= `PNPEE_ACT_RST;
            tx_ff <= '0;
            rx_ff <= 16'h0;
            bit_ff <= 5'h0;
            nbits_ff <= 5'h0;
            div_ff <= 8'h0;
            cs_ff <= 1'b0;
            sk_ff <= 1'b0;
            op_rd_ff <= 1'b0;
            irq_ff <= 16'h0;
            irq_oe_ff <= 16'h0;
            for (int k = 0; k < 6; k++) shad_ff[k] <= 8'h0;
        end else begin
            hstate_ff <= nxt_hstate;
            eng_ff <= nxt_eng;
            rdata_ff <= nxt_rdata;
            rd_pend_ff <= nxt_rd_pend;
            rptr_ff <= nxt_rptr;
            wptr_ff <= nxt_wptr;
            wen_ff <= nxt_wen;
            init_ff <= nxt_init;
            cnt_ff <= nxt_cnt;
            act_ff <= nxt_act;
            tx_ff <= nxt_tx;
            rx_ff <= nxt_rx;
            bit_ff <= nxt_bit;
            nbits_ff <= nxt_nbits;
            div_ff <= nxt_div;
            cs_ff <= nxt_cs;
            sk_ff <= nxt_sk;
            op_rd_ff <= nxt_op_rd;
            irq_ff <= nxt_irq;
            irq_oe_ff <= nxt_irq_oe;
            for (int k = 0; k < 6; k++) shad_ff[k] <= nxt_shad[k];
        end
    end

    // Two-stage synchronisers for pin inputs
    always_ff @(posedge clk) begin
        do_s1_ff <= ee_do;
        do_s2_ff <= do_s1_ff;
        aen_s1_ff <= activation_enable_pin;
        aen_s2_ff <= aen_s1_ff;
        cirq_s1_ff <= card_irq;
        cirq_s2_ff <= cirq_s1_ff;
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_no_bad_level: assert property (!init_ff |=> (isa_irq_oe & 16'h6347) == 16'h0) // R16
        else $error("interrupt driven on an invalid level");
    a_irq_oe_level: assert property (!init_ff && pnpee_lvl_ok(shad_ff[IRQ0][3:0]) // R1
        |=> isa_irq_oe[$past(shad_ff[IRQ0][3:0])]) else $error("entry A level not driven");
    a_irq_low_type: assert property (!init_ff && pnpee_lvl_ok(shad_ff[IRQ0][3:0]) // R2
        && !shad_ff[IRQ0][5] && !shad_ff[IRQ0][6]
        |=> isa_irq[$past(shad_ff[IRQ0][3:0])] == !$past(cirq_s2_ff[0]))
        else $error("low type output not inverted");
    a_irq_polarity: assert property (!init_ff && pnpee_lvl_ok(shad_ff[IRQ0+1][3:0]) // R3
        && shad_ff[IRQ0+1][5]
        |=> isa_irq[$past(shad_ff[IRQ0+1][3:0])]
            == ($past(cirq_s2_ff[1]) ^ $past(shad_ff[IRQ0+1][6])))
        else $error("input polarity wrong");
    a_act_gate: assert property ($fell(init_ff) && !$past(aen_s2_ff) |-> ld_activate == 4'h0) // R6
        else $error("activation without enable pin");
    a_no_read_outside: assert property (eng_ff == st_idle && !init_ff && !in_cfg // R7
        |=> !(eng_ff == st_shift && op_rd_ff)) else $error("read outside config state");
    a_rptr_step: assert property (f.in_valid && f.in_ready && !f.flush // R8
        |=> rptr_ff == $past(rptr_ff) + 1'b1) else $error("read pointer did not step");
    a_rptr_reset: assert property (rst_cmd |=> rptr_ff == '0 && !f.out_valid) // R10
        else $error("read pointer reset failed");
    a_no_write_outside: assert property (acc_wr && avs_address == `PNPEE_REG_WDATA && !in_cfg // R11
        |=> wptr_ff == $past(wptr_ff) && eng_ff == st_idle) else $error("write outside config");
    a_wptr_hold: assert property (op_rd_ff && eng_ff != st_idle |=> $stable(wptr_ff)) // R12
        else $error("read changed write pointer");
    a_oe_wait_key: assert property (hstate_ff == hs_wfk && !init_ff // R15
        |-> !ee_cs_oe && !ee_sk_oe && !ee_di_oe) else $error("pins driven in wait-for-key");

    c_init_done: cover property ($fell(init_ff));
    c_byte_push: cover property (f.in_valid && !f.in_ready ##1 f.in_ready);
    c_rptr_reset: cover property (rst_cmd);
    c_word_write: cover property (acc_wr && avs_address == `PNPEE_REG_WDATA && in_cfg && wen_ff);
endmodule : pnpee_ctrl

// [hdl/pnpee_fifo.sv]
// Byte FIFO between EEPROM fetches and host reads.
// Assumes one clock and a synchronous active-high reset; flush empties it.
`timescale 1ns/1ps
module pnpee_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic reset,
    pnpee_fifo_if.fifo f
);
    import pnpee_pkg::*;
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem_ff [DEPTH];
    logic [PW:0] wp_ff;
    logic [PW:0] rp_ff;
    logic [PW:0] nxt_wp;
    logic [PW:0] nxt_rp;
    logic push;
    logic pop;

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("pnpee_fifo: DEPTH must be a power of two, at least 2");
    end

    // Full and empty from wrap bit and index
    assign f.in_ready = (wp_ff[PW] == rp_ff[PW]) || (wp_ff[PW-1:0] != rp_ff[PW-1:0]);
    assign f.out_valid = wp_ff != rp_ff;
    assign f.out_data = mem_ff[rp_ff[PW-1:0]];
    assign push = f.in_valid && f.in_ready && !f.flush;
    assign pop = f.out_valid && f.out_ready && !f.flush;

    // Pointer updates
    always_comb begin
        nxt_wp = wp_ff;
        nxt_rp = rp_ff;
        if (f.flush) begin
            nxt_wp = '0;
            nxt_rp = '0;
        end else begin
            if (push) nxt_wp = wp_ff + 1'b1;
            if (pop) nxt_rp = rp_ff + 1'b1;
        end
    end

    // Pointer and storage registers
    always_ff @(posedge clk) begin
        if (reset) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
        if (push) mem_ff[wp_ff[PW-1:0]] <= f.in_data;
    end
endmodule : pnpee_fifo

// [include/pnpee_fifo_if.sv]
// Valid/ready stream between the access engine and its byte FIFO.
// Assumes both ends sit on one clock.
`timescale 1ns/1ps
interface pnpee_fifo_if #(parameter int W = 8);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    logic flush;
    modport src (output in_valid, in_data, out_ready, flush, input in_ready, out_valid, out_data);
    modport fifo (input in_valid, in_data, out_ready, flush, output in_ready, out_valid, out_data);
endinterface : pnpee_fifo_if

// [include/pnpee_pkg.sv]
// Types and helpers of the EEPROM access block.
// Assumes nothing beyond a SystemVerilog compiler.
package pnpee_pkg;
    typedef enum logic [1:0] {
        hs_wfk = 2'h0,
        hs_sleep = 2'h1,
        hs_config = 2'h2
    } pnpee_hstate_t;

    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_shift = 3'h1,
        st_gap = 3'h2,
        st_push_lo = 3'h3,
        st_push_hi = 3'h4
    } pnpee_eng_t;

    // Levels that an interrupt entry may route to
    function automatic logic pnpee_lvl_ok(input logic [3:0] l);
        case (l)
            4'h3, 4'h4, 4'h5, 4'h7, 4'hA, 4'hB, 4'hC, 4'hF: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : pnpee_lvl_ok
endpackage : pnpee_pkg

// [include/pnpee_regs.svh]
// Register map, field positions, reset values and timing counts of the EEPROM access block.
// Included by the controller and the testbench by bare name; definitions only.
`ifndef PNPEE_REGS_SVH
`define PNPEE_REGS_SVH
// Register byte addresses
`define PNPEE_REG_STATE 8'h00
`define PNPEE_REG_STATUS 8'h04
`define PNPEE_REG_RDATA 8'h08
`define PNPEE_REG_WDATA 8'h0C
`define PNPEE_REG_WCMD 8'h10
`define PNPEE_REG_IRQCFG 8'h14
`define PNPEE_REG_ACT 8'h18
`define PNPEE_IDX_CFG 8'h26
`define PNPEE_REG_CFG (`PNPEE_IDX_CFG << 2)
// Command values
`define PNPEE_CFG_RPTR_RST 8'h03
`define PNPEE_WCMD_EWEN 8'h01
`define PNPEE_WCMD_EWDS 8'h02
// Serial opcodes: start bit and two op bits, then extension bits for misc
`define PNPEE_OP_READ 3'h6
`define PNPEE_OP_WRITE 3'h5
`define PNPEE_OP_MISC 3'h4
`define PNPEE_OPX_EWEN 2'h3
`define PNPEE_OPX_EWDS 2'h0
// Fields of a stored interrupt byte and of the activation byte
`define PNPEE_IRQ_LVL 3:0
`define PNPEE_IRQ_TYPE_LVL 4
`define PNPEE_IRQ_TYPE_HI 5
`define PNPEE_IRQ_POL 6
`define PNPEE_ACT_BITS 3:0
// Stored default bytes fetched at power-up
`define PNPEE_EE_BASE 8'h16
`define PNPEE_EE_IRQA 8'h17
`define PNPEE_EE_ACT 8'h1B
`define PNPEE_INIT_WORDS 2'h3
// Reset values
`define PNPEE_PTR_RST '0
`define PNPEE_WEN_RST 1'h0
`define PNPEE_ACT_RST 4'h0
// Timing
`define PNPEE_CLK_NS 100
`define PNPEE_SK_HALF_NS 500
`define PNPEE_SK_HALF_CYC ((`PNPEE_SK_HALF_NS + `PNPEE_CLK_NS - 1) / `PNPEE_CLK_NS)
`define PNPEE_TWC_MS 10
`endif

// [testbench/pnpee_eeprom_model.sv]
// Behavioural three-wire serial EEPROM on the far side of the access block.
// Assumes CS high frames, MSB first, DI sampled on SK rise; AW address bits.
`timescale 1ns/1ps
module pnpee_eeprom_model #(
    parameter int AW = 6
) (
    input wire logic cs,
    input wire logic sk,
    input wire logic di,
    output logic do_o
);
    logic [15:0] mem [0:(1<<AW)-1];
    logic [31:0] sh;
    logic [15:0] rd;
    logic wen;
    int cnt;
    // Byte a holds a, except the stored defaults; distinct levels 3,4,15 in use
    initial begin
        for (int i = 0; i < (1 << AW); i++) mem[i] = {8'(2*i+1), 8'(2*i)};
        mem[11] = 16'h0316;
        mem[12] = 16'h0664;
        mem[13] = 16'h053F;
        wen = 1'b0;
        do_o = 1'b0;
    end
    // Frame start clears the shifter
    always @(posedge cs) begin
        cnt = 0;
        sh = '0;
    end
    // Shift in; writes land instantly, so no write cycle wait is needed
    always @(posedge sk) if (cs) begin
        sh = {sh[30:0], di};
        cnt++;
        if (cnt == 3 + AW && sh[AW+2:AW] == 3'h4) wen = (sh[AW-1:AW-2] == 2'h3);
        if (cnt == 19 + AW && sh[18+AW:16+AW] == 3'h5 && wen) mem[sh[15+AW:16]] = sh[15:0];
    end
    // Data out changes on SK fall after the address
    always @(negedge sk) if (cs) begin
        if (cnt == 3 + AW && sh[AW+2:AW] == 3'h6) rd = mem[sh[AW-1:0]];
        if (cnt >= 3 + AW) begin
            do_o = rd[15];
            rd = {rd[14:0], ~rd[15]};
        end
    end
    // Released line shows no stale value
    always @(negedge cs) do_o = ~do_o;
endmodule : pnpee_eeprom_model

// [testbench/test_pnp_eeprom_config_access.sv]
// Self-checking bench of the EEPROM access block.
// Assumes pnpee_ctrl on Avalon-MM and the serial EEPROM model.
`timescale 1ns/1ps
`include "pnpee_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module test_pnp_eeprom_config_access;
    logic clk = 0;
    logic reset = 1;
    logic [7:0] addr = 0;
    logic rd = 0;
    logic wr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] card_irq = 0;
    logic aen = 1;
    logic [31:0] rdata, q;
    logic wait_rq, cs, cs_oe, sk, sk_oe, di, di_oe, dout;
    logic [15:0] irq, irq_oe;
    logic [3:0] ld_act;
    int mismatches = 0;
    int checks_done = 0;
    // Clock
    always #50 clk = ~clk;
    pnpee_ctrl uut (.clk(clk), .reset(reset), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wait_rq), .ee_cs(cs), .ee_cs_oe(cs_oe), .ee_sk(sk),
        .ee_sk_oe(sk_oe), .ee_di(di), .ee_di_oe(di_oe), .ee_do(dout),
        .activation_enable_pin(aen), .card_irq(card_irq), .isa_irq(irq),
        .isa_irq_oe(irq_oe), .ld_activate(ld_act));
    pnpee_eeprom_model eep (.cs(cs & cs_oe), .sk(sk & sk_oe), .di(di), .do_o(dout));
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        @(posedge clk);
        while (wait_rq !== 1'b0) @(posedge clk);
        q = rdata;
        rd <= 0;
        wr <= 0;
    endtask : bus
    // Poll a status bit until it reaches a value
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            bus(0, `PNPEE_REG_STATUS, 0);
            n++;
        end while (q[b] !== v && n < 5000);
        `CHK(q[b], v)
    endtask : poll
    function automatic logic [7:0] exp_byte(input int a);
        case (a)
            23: return 8'h03;
            24: return 8'h64;
            25: return 8'h06;
            26: return 8'h3F;
            27: return 8'h05;
            default: return 8'(a);
        endcase
    endfunction : exp_byte
    // Power-up defaults, pin release and refused access in wait-for-key
    task automatic t_powerup;
        poll(3, 0);
        bus(0, `PNPEE_REG_IRQCFG, 0);
        `CHK(q, 32'h3F066403)
        bus(0, `PNPEE_REG_ACT, 0);
        `CHK({q[3:0], ld_act}, 8'h55)
        `CHK({cs_oe, sk_oe, di_oe}, 3'h0)
        bus(0, `PNPEE_REG_RDATA, 0);
        `CHK(q, 32'h0)
        bus(1, `PNPEE_REG_WCMD, `PNPEE_WCMD_EWEN);
        bus(1, `PNPEE_REG_WDATA, 32'hAAAA);
    endtask : t_powerup
    // Routing, polarity and invalid level
    task automatic t_irq;
        @(posedge clk);
        card_irq <= 4'h0;
        repeat (5) @(posedge clk);
        `CHK(irq_oe, 16'h8018)
        `CHK(irq & 16'h8018, 16'h0018)
        card_irq <= 4'hF;
        repeat (5) @(posedge clk);
        `CHK(irq & 16'h8018, 16'h8000)
    endtask : t_irq
    // Fill until full, drain all 32 bytes in order
    task automatic t_fifo;
        bus(1, `PNPEE_REG_STATE, 2);
        poll(4, 1);
        for (int i = 0; i < 32; i++) begin
            poll(0, 1);
            bus(0, `PNPEE_REG_RDATA, 0);
            `CHK(q[7:0], exp_byte(i))
        end
        bus(1, `PNPEE_REG_CFG, `PNPEE_CFG_RPTR_RST);
        poll(0, 1);
        bus(0, `PNPEE_REG_RDATA, 0);
        `CHK(q[7:0], 8'h00)
    endtask : t_fifo
    // Enable, two words, disable, a refused word
    task automatic t_write;
        bus(1, `PNPEE_REG_WCMD, `PNPEE_WCMD_EWEN);
        bus(1, `PNPEE_REG_WDATA, 32'hBEEF);
        bus(1, `PNPEE_REG_WDATA, 32'h1234);
        bus(1, `PNPEE_REG_WCMD, `PNPEE_WCMD_EWDS);
        bus(1, `PNPEE_REG_WDATA, 32'h5555);
        // Sleep stops prefetch so the engine can go idle
        bus(1, `PNPEE_REG_STATE, 1);
        poll(1, 0);
        `CHK(eep.mem[0], 16'hBEEF)
        `CHK(eep.mem[1], 16'h1234)
        `CHK(eep.mem[2], 16'h0504)
    endtask : t_write
    // Mid-run reset with the enable pin low: pins driven while loading, nothing activated
    task automatic t_noact;
        @(posedge clk);
        aen <= 0;
        reset <= 1;
        repeat (8) @(posedge clk);
        reset <= 0;
        repeat (2) @(posedge clk);
        `CHK({cs_oe, sk_oe, di_oe}, 3'h7)
        poll(3, 0);
        bus(0, `PNPEE_REG_ACT, 0);
        `CHK({q[3:0], ld_act}, 8'h00)
    endtask : t_noact
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    // Watchdog
    initial begin
        repeat (80000) @(posedge clk);
        mismatches++;
        test_done();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 0;
        t_powerup();
        t_irq();
        t_fifo();
        t_write();
        t_noact();
        test_done();
    end
endmodule : test_pnp_eeprom_config_access
